// ==== verilog/ams_seq.sv ====
// Strobe sequencer for asynchronous and burst memories behind an APB slave
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`include "ams_params.svh"
module ams_seq import ams_pkg::*; (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory control pins
  output logic      [3:0]  chip_space_select_n,
  output logic      [3:0]  byte_lane_enable_n,
  output logic      [19:0] ext_addr,
  output logic             async_output_enable_n,
  output logic             async_read_strobe_n,
  output logic             async_write_strobe_n,
  input  wire logic        async_ready,
  // Data pins
  input  wire logic [31:0] ext_data_in,
  output logic      [31:0] ext_data_out,
  output logic             ext_data_oe,
  // Shared burst pins and clock
  output logic             column_strobe_n,
  output logic             row_strobe_n,
  output logic             sdram_write_n,
  output logic             half_rate_clock_out
);
  ams_state_t  state;
  ams_state_t  next_state;
  logic [6:0]  cnt;
  logic [6:0]  next_cnt;
  ams_timing_t cfg;
  logic [31:0] cfg_rd;
  logic [31:0] cfg_ra;
  ams_cmd_t    cmd_q;
  ams_cmd_t    cmd_in;
  logic [19:0] addr_q;
  logic [19:0] prev_addr;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        rdy_meta;
  logic        rdy_sync;
  logic        ext_seen;
  logic        prev_bwr;
  logic        early;
  logic        busy;
  logic        apb_acc;
  logic        cmd_go;
  logic        cfg_we;
  logic        smp_en;
  logic        frame;
  logic        burst_frame;
  logic [6:0]  setup_v;
  logic [6:0]  strobe_v;
  logic [6:0]  hold_v;
  logic [6:0]  ovh_v;

  assign cfg     = ams_timing_t'(cfg_rd);
  assign cmd_in  = ams_cmd_t'(pwdata);
  assign apb_acc = psel && penable && pready;
  assign busy    = state != ST_IDLE && state != ST_OVH;
  assign cmd_go  = apb_acc && pwrite && paddr == `AMS_OFF_CMD && !busy;
  assign cfg_we  = apb_acc && pwrite && paddr <= `AMS_OFF_CFG_LAST
                   && paddr[1:0] == 2'b00;

  // Control words; port b follows the space of the access
  ams_cfg_mem u_cfg (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (cfg_we),
    .waddr   (paddr[3:2]),
    .wdata   (pwdata & `AMS_CFG_MASK),
    .ra_addr (paddr[3:2]),
    .rb_addr (cmd_go ? cmd_in.space : cmd_q.space),
    .ra_data (cfg_ra),
    .rb_data (cfg_rd)
  );

  // Programmed counts of the current access, zero setup or strobe is one
  always_comb begin
    if (cmd_q.write) begin
      setup_v  = (cfg.ws == 4'h0) ? 7'd1 : 7'(cfg.ws);
      strobe_v = (cfg.write_strobe_cycles == 6'h0) ? 7'd1 : 7'(cfg.write_strobe_cycles);
      hold_v   = 7'(cfg.wh);
      ovh_v    = (cfg.wh == 3'h0) ? `AMS_OVH_WR_NOH : `AMS_OVH_WR;
    end else begin
      setup_v  = (cfg.rs == 4'h0) ? 7'd1 : 7'(cfg.rs);
      strobe_v = (cfg.rst == 6'h0) ? 7'd1 : 7'(cfg.rst);
      hold_v   = 7'(cfg.rh);
      ovh_v    = `AMS_OVH_RD - 7'(cfg.rh);
    end
    smp_en = strobe_v >= `AMS_RDY_MIN_STB
             && (setup_v + strobe_v) >= `AMS_RDY_MIN_SUM;
  end

  // Two flip-flop ready synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      rdy_meta <= async_ready;
      rdy_sync <= rdy_meta;
    end
  end

  // Next state and the single interval counter
  always_comb begin
    next_state = state;
    next_cnt   = (cnt == 7'd0) ? 7'd0 : cnt - 7'd1;
    case (state)
      ST_IDLE, ST_OVH: begin
        if (cmd_go) begin
          next_state = ST_START;
        end else if (state == ST_OVH && cnt == 7'd0) begin
          next_state = ST_IDLE;
        end
      end
      ST_START: begin
        if (cfg.burst && cmd_q.write && early) begin
          next_state = ST_BPRE;
          next_cnt   = `AMS_PHASE_LAST;
        end else if (cfg.burst) begin
          next_state = ST_BALIGN;
        end else begin
          next_state = ST_SETUP;
          next_cnt   = setup_v - 7'd1;
        end
      end
      ST_SETUP: begin
        if (cnt == 7'd0) begin
          next_state = ST_STROBE;
          next_cnt   = strobe_v - 7'd1;
        end
      end
      ST_STROBE, ST_WAIT: begin
        if (state == ST_STROBE && smp_en && !ext_seen
            && cnt == `AMS_RDY_POINT && !rdy_sync) begin
          next_state = ST_WAIT;
        end else if ((state == ST_STROBE && cnt == 7'd0)
                     || (state == ST_WAIT && rdy_sync)) begin
          if (hold_v != 7'd0) begin
            next_state = ST_HOLD;
            next_cnt   = hold_v - 7'd1;
          end else begin
            next_state = (ovh_v == 7'd0) ? ST_IDLE : ST_OVH;
            next_cnt   = ovh_v - 7'd1;
          end
        end
      end
      ST_HOLD: begin
        if (cnt == 7'd0) begin
          next_state = (ovh_v == 7'd0) ? ST_IDLE : ST_OVH;
          next_cnt   = ovh_v - 7'd1;
        end
      end
      ST_BPRE: begin
        if (cnt == 7'd0) begin
          next_state = ST_BALIGN;
        end
      end
      ST_BALIGN: begin
        if (half_rate_clock_out) begin
          next_state = ST_BCMD;
          next_cnt   = `AMS_PHASE_LAST;
        end
      end
      ST_BCMD: begin
        if (cnt == 7'd0) begin
          next_state = cmd_q.write ? ST_IDLE : ST_BLAT;
          next_cnt   = `AMS_SBS_LAT;
        end
      end
      ST_BLAT: begin
        if (cnt == 7'd0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State, counter and extension flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      cnt      <= 7'd0;
      ext_seen <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      ext_seen <= (next_state == ST_WAIT) || (ext_seen && state != ST_START);
    end
  end

  // Half rate clock, toggles every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_rate_clock_out <= 1'b0;
    end else begin
      half_rate_clock_out <= !half_rate_clock_out;
    end
  end

  // Framing of the next cycle
  assign frame = next_state == ST_SETUP || next_state == ST_STROBE
                 || next_state == ST_WAIT || next_state == ST_HOLD;
  assign burst_frame = next_state == ST_BCMD;

  // Memory pins, all inactive from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_space_select_n   <= 4'hf;
      byte_lane_enable_n    <= 4'hf;
      async_output_enable_n <= 1'b1;
      async_read_strobe_n   <= 1'b1;
      async_write_strobe_n  <= 1'b1;
      column_strobe_n       <= 1'b1;
      row_strobe_n          <= 1'b1;
      sdram_write_n         <= 1'b1;
      ext_addr              <= 20'h0;
    end else begin
      chip_space_select_n <= (frame || burst_frame || next_state == ST_OVH)
                             ? ~(4'h1 << cmd_q.space) : 4'hf;
      byte_lane_enable_n <= (frame || burst_frame) ? cmd_q.be_n : 4'hf;
      async_output_enable_n <= !(frame && !cmd_q.write);
      async_read_strobe_n <= !((next_state == ST_STROBE
                               || next_state == ST_WAIT) && !cmd_q.write);
      async_write_strobe_n <= !((next_state == ST_STROBE
                                || next_state == ST_WAIT) && cmd_q.write);
      column_strobe_n <= !burst_frame;
      row_strobe_n    <= !(next_state == ST_BLAT);
      sdram_write_n   <= !(burst_frame && cmd_q.write);
      ext_addr        <= addr_q;
    end
  end

  // Write data drive; first burst write of a run turns on early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_data_out <= 32'h0;
      ext_data_oe  <= 1'b0;
    end else begin
      ext_data_out <= wdata_q;
      ext_data_oe  <= cmd_q.write && (frame || burst_frame
                      || next_state == ST_BPRE
                      || (early && next_state == ST_BALIGN));
    end
  end

  // Command, address, data and burst run tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q     <= ams_cmd_t'(32'h0);
      addr_q    <= 20'h0;
      wdata_q   <= 32'h0;
      rdata_q   <= 32'h0;
      prev_addr <= 20'h0;
      prev_bwr  <= 1'b0;
      early     <= 1'b1;
    end else begin
      if (cmd_go) begin
        cmd_q <= cmd_in;
        early <= !(prev_bwr && cmd_in.write
                   && addr_q == prev_addr + 20'h1);
      end
      if (apb_acc && pwrite && paddr == `AMS_OFF_ADDR && !busy) begin
        addr_q <= pwdata[19:0];
      end
      if (apb_acc && pwrite && paddr == `AMS_OFF_WDATA && !busy) begin
        wdata_q <= pwdata;
      end
      if (state == ST_START) begin
        prev_bwr  <= cfg.burst && cmd_q.write;
        prev_addr <= addr_q;
      end
      if ((state == ST_STROBE || state == ST_WAIT) && next_state != state
          && next_state != ST_WAIT && !cmd_q.write) begin
        rdata_q <= ext_data_in;
      end else if (state == ST_BLAT && cnt == 7'd0) begin
        rdata_q <= ext_data_in;
      end
    end
  end

  // APB answer: one wait state, error on unmapped or busy command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && penable && !pready) begin
        if (paddr <= `AMS_OFF_CFG_LAST && paddr[1:0] == 2'b00) begin
          prdata <= cfg_ra;
        end else if (paddr == `AMS_OFF_CMD) begin
          prdata  <= 32'(cmd_q);
          pslverr <= pwrite && busy;
        end else if (paddr == `AMS_OFF_ADDR) begin
          prdata <= {12'h0, addr_q};
        end else if (paddr == `AMS_OFF_WDATA) begin
          prdata <= wdata_q;
        end else if (paddr == `AMS_OFF_RDATA) begin
          prdata <= rdata_q;
        end else if (paddr == `AMS_OFF_STAT) begin
          prdata <= {29'h0, state == ST_OVH, rdy_sync, busy};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Helper counters for the checks below
  logic [6:0] pre_len;
  logic [6:0] low_len;
  logic [6:0] ovh_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_len <= 7'd0;
      low_len <= 7'd0;
      ovh_len <= 7'd0;
    end else begin
      pre_len <= (state == ST_SETUP) ? pre_len + 7'd1 : 7'd0;
      low_len <= (!async_read_strobe_n || !async_write_strobe_n)
                 ? low_len + 7'd1 : 7'd0;
      ovh_len <= (state == ST_OVH) ? ovh_len + 7'd1 : 7'd0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_strobe_fell;
    $fell(async_read_strobe_n) || $fell(async_write_strobe_n);
  endsequence
  sequence s_cap_edge;
    !half_rate_clock_out ##1 half_rate_clock_out;
  endsequence

  a_setup_len: assert property (s_strobe_fell |-> pre_len == setup_v
    && !(&chip_space_select_n))
    else $error("setup length differs from programmed count");
  a_strobe_width: assert property (($rose(async_read_strobe_n)
    || $rose(async_write_strobe_n)) && !ext_seen |-> low_len == strobe_v)
    else $error("strobe width differs from programmed count");
  a_hold_stable: assert property (state == ST_HOLD |-> $stable(ext_addr)
    && $stable(byte_lane_enable_n) && !(&chip_space_select_n))
    else $error("select signals moved during hold");
  a_rdy_sample: assert property (state == ST_STROBE && smp_en && !ext_seen
    && cnt == `AMS_RDY_POINT && !rdy_sync |=> state == ST_WAIT
    && (!async_read_strobe_n || !async_write_strobe_n))
    else $error("low ready did not stretch the strobe");
  a_rdy_release: assert property (state == ST_WAIT && rdy_sync |=>
    async_read_strobe_n && async_write_strobe_n ##1
    async_read_strobe_n && async_write_strobe_n)
    else $error("strobe not released after ready");
  a_ovh_len: assert property ($past(state) == ST_OVH && state == ST_IDLE
    |-> ovh_len == ovh_v && (&chip_space_select_n))
    else $error("select overhead length wrong");
  a_burst_pins: assert property (state == ST_BCMD |-> !column_strobe_n
    && row_strobe_n && sdram_write_n == !cmd_q.write)
    else $error("burst pins wrong during address phase");
  a_burst_cap: assert property (state == ST_BLAT && cnt == 7'd0 |->
    s_cap_edge ##0 rdata_q == $past(ext_data_in))
    else $error("burst read data not captured on clock rise");
  a_half_clk: assert property (half_rate_clock_out |=>
    !half_rate_clock_out ##1 half_rate_clock_out)
    else $error("half rate clock phase not one cycle");
  a_early_data: assert property (state == ST_BPRE |-> ext_data_oe
    && column_strobe_n)
    else $error("early write data not driven");
endmodule : ams_seq

// ==== verilog/ams_params.svh ====
// Constants of the asynchronous memory strobe sequencer
//
// Functional notes
// - Read: select, lanes, address, output enable valid setup cycles before strobe.
// - Unstretched read strobe stays low exactly the read strobe count.
// - After read strobe rises, select, address, lanes stay stable for hold.
// - Write: select, address, lanes, data valid setup cycles before strobe.
// - Unstretched write strobe stays low exactly the write strobe count.
// - After write strobe rises, select, address, lanes, data stay for hold.
// - Ready passes a synchroniser; may act one cycle late.
// - Read: ready sampled strobe minus three cycles in; low stretches strobe.
// - Write: ready sampled strobe minus three cycles in; low stretches strobe.
// - Extended read strobe rises three to four cycles after ready rises.
// - Extended write strobe rises three to four cycles after ready rises.
// - Pins are cycle framed; select may linger up to seven cycles.
// - After a read, select stays active seven minus read hold cycles.
// - After a write, select lingers three cycles, or four if hold zero.
// - All six counts come from per select space control registers.
// - Burst access uses shared row, column, write pins as burst strobes.
// - First burst write of an adjacent run drives data one clock early.
// - Burst read data captured on rising edge of half rate clock.
// - Half rate clock: high and low phases each one clock period.
`ifndef AMS_PARAMS_SVH
`define AMS_PARAMS_SVH
// Register byte offsets
`define AMS_OFF_CFG_LAST 8'h0c
`define AMS_OFF_CMD      8'h10
`define AMS_OFF_ADDR     8'h14
`define AMS_OFF_WDATA    8'h18
`define AMS_OFF_RDATA    8'h1c
`define AMS_OFF_STAT     8'h20
// Writable bits of a space control word
`define AMS_CFG_MASK     32'h9fff1fff
// Timing counts in clock cycles
`define AMS_OVH_RD       7'd7
`define AMS_OVH_WR       7'd3
`define AMS_OVH_WR_NOH   7'd4
`define AMS_RDY_POINT    7'd2
`define AMS_RDY_MIN_STB  7'd3
`define AMS_RDY_MIN_SUM  7'd4
`define AMS_PHASE_LAST   7'd1
`define AMS_SBS_LAT      7'd2
`endif

// ==== verilog/ams_pkg.sv ====
// Types shared by the asynchronous memory strobe sequencer
package ams_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_SETUP, ST_STROBE, ST_WAIT, ST_HOLD, ST_OVH,
    ST_BPRE, ST_BALIGN, ST_BCMD, ST_BLAT
  } ams_state_t;
  // Per space control word
  typedef struct packed {
    logic       burst;
    logic [1:0] rsv1;
    logic [2:0] wh;
    logic [5:0] write_strobe_cycles;
    logic [3:0] ws;
    logic [2:0] rsv0;
    logic [2:0] rh;
    logic [5:0] rst;
    logic [3:0] rs;
  } ams_timing_t;
  // Command word
  typedef struct packed {
    logic [19:0] rsv2;
    logic [3:0]  be_n;
    logic [2:0]  rsv1;
    logic        write;
    logic [1:0]  rsv0;
    logic [1:0]  space;
  } ams_cmd_t;
endpackage : ams_pkg

// ==== verilog/ams_cfg_mem.sv ====
// Control words of the four select spaces, two registered read ports
module ams_cfg_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Write port
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read ports
  input  wire logic [1:0]  ra_addr,
  input  wire logic [1:0]  rb_addr,
  output logic      [31:0] ra_data,
  output logic      [31:0] rb_data
);
  logic [31:0] mem [4];

  // One word per space
  for (genvar i = 0; i < 4; i++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[i] <= 32'h0;
      end else if (we && waddr == 2'(i)) begin
        mem[i] <= wdata;
      end
    end
  end

  // Registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_data <= 32'h0;
      rb_data <= 32'h0;
    end else begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end
endmodule : ams_cfg_mem

// ==== tb/ams_mem_model.sv ====
// Behavioural memory on the far side of the strobe sequencer
module ams_mem_model import ams_pkg::*; (
  // Clock and pins from the sequencer
  input  wire logic        pclk,
  input  wire logic [3:0]  chip_space_select_n,
  input  wire logic [19:0] ext_addr,
  input  wire logic        async_output_enable_n,
  input  wire logic        async_read_strobe_n,
  input  wire logic        async_write_strobe_n,
  input  wire logic [31:0] ext_data_out,
  input  wire logic        ext_data_oe,
  input  wire logic        column_strobe_n,
  input  wire logic        row_strobe_n,
  input  wire logic        sdram_write_n,
  input  wire logic        half_rate_clock_out,
  // Strobe cycles to hold ready low, zero for a prompt memory
  input  wire logic [7:0]  stall,
  // Answers to the sequencer
  output logic             async_ready,
  output logic      [31:0] ext_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic [7:0]  cnt;
  logic        sel;
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    async_ready = 1'b1;
    ext_data_in = 32'h0;
    cnt = 8'h00;
  end
  assign sel = (chip_space_select_n != 4'hf);
  // Slow memory holds ready low, then high until the select ends
  always @(posedge pclk) begin
    if (!sel) begin
      cnt <= 8'h00;
      async_ready <= (stall == 8'h00);
    end else if (!async_read_strobe_n || !async_write_strobe_n) begin
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 >= stall) async_ready <= 1'b1;
    end
  end
  // Drives data while enabled, otherwise a pattern that keeps changing
  always @(posedge pclk) begin
    if (!async_output_enable_n || !row_strobe_n) begin
      ext_data_in <= mem[ext_addr[3:0]];
    end else begin
      ext_data_in <= ~ext_data_in;
    end
  end
  // Writes sampled on the clock: each strobe-low cycle, and the burst
  // address phase at the edge where the half rate clock rises
  always @(posedge pclk) begin
    if (sel && !async_write_strobe_n && ext_data_oe) begin
      mem[ext_addr[3:0]] <= ext_data_out;
    end else if (!column_strobe_n && !sdram_write_n
                 && !half_rate_clock_out) begin
      mem[ext_addr[3:0]] <= ext_data_out;
    end
  end
endmodule : ams_mem_model

// ==== tb/testbench.sv ====
// Self-checking bench for the strobe sequencer and its memory model
module testbench import ams_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, stall;
  logic [31:0] pwdata, prdata, ext_data_in, ext_data_out;
  logic        async_output_enable_n, async_ready, ext_data_oe;
  logic        async_read_strobe_n, async_write_strobe_n;
  logic        column_strobe_n, row_strobe_n, sdram_write_n;
  logic        half_rate_clock_out, hc_prev;
  logic [3:0]  chip_space_select_n, byte_lane_enable_n;
  logic [19:0] ext_addr;
  logic [31:0] shadow [16];
  int          errors, total_checks;
  int          prev_bw = -2;
  ams_timing_t tm;
  ams_seq dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .chip_space_select_n,
    .byte_lane_enable_n, .ext_addr, .async_output_enable_n,
    .async_read_strobe_n, .async_write_strobe_n, .async_ready,
    .ext_data_in, .ext_data_out, .ext_data_oe, .column_strobe_n,
    .row_strobe_n, .sdram_write_n, .half_rate_clock_out);
  ams_mem_model mem_u (.pclk, .chip_space_select_n, .ext_addr,
    .async_output_enable_n, .async_read_strobe_n, .async_write_strobe_n,
    .ext_data_out, .ext_data_oe, .column_strobe_n, .row_strobe_n,
    .sdram_write_n, .half_rate_clock_out, .stall, .async_ready,
    .ext_data_in);
  // Clock generator
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Compares a seen value with the expected one
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then stops
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // Setup or strobe count of zero acts as one
  function automatic logic [7:0] at_least1(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction : at_least1
  // Cycles the select stays low after the strobe rises
  function automatic logic [7:0] tail(input logic wr, input logic [2:0] h);
    if (!wr) return 8'd7;
    return {5'h00, h} + ((h == 3'h0) ? 8'd4 : 8'd3);
  endfunction : tail
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Programs a space, runs one access and measures the pin frame
  task automatic run(input logic [1:0] sp, input logic wr,
                     input ams_timing_t t, input logic [19:0] a,
                     input logic [7:0] st);
    logic [31:0] d, q;
    logic        e, sel, stb, fell, done, first;
    ams_cmd_t    cmd;
    int          nsu, ns, nt, nr, nc, nro, nw, npre, bad;
    d = $urandom;
    cmd = '0;
    cmd.space = sp;
    cmd.write = wr;
    cmd.be_n = wr ? 4'h0 : 4'($urandom);
    {nsu, ns, nt, nr, nc, nro, nw, npre, bad} = '0;
    fell = 1'b0;
    done = 1'b0;
    first = (a != prev_bw + 1);
    stall <= st;
    apb(1'b1, {4'h0, sp, 2'b00}, t, q, e);
    apb(1'b1, 8'h14, {12'h000, a}, q, e);
    apb(1'b1, 8'h18, d, q, e);
    apb(1'b1, 8'h10, cmd, q, e);
    for (int c = 0; c < 300 && !done; c++) begin
      @(negedge pclk);
      sel = !chip_space_select_n[sp];
      stb = wr ? async_write_strobe_n : async_read_strobe_n;
      if (!stb && !fell) begin
        check(ext_addr, a);
        check(byte_lane_enable_n, cmd.be_n);
        check({async_output_enable_n, ext_data_oe}, {wr, wr});
        if (wr) check(ext_data_out, d);
      end
      if (!stb) begin
        fell = 1'b1;
        ns++;
        if (async_ready) nr++;
      end else if (sel && fell) begin
        nt++;
        if (ext_addr !== a || (wr && ext_data_out !== d)) bad++;
      end else if (sel) nsu++;
      if (!column_strobe_n) nc++;
      if (!row_strobe_n) nro++;
      if (!sdram_write_n) nw++;
      if (ext_data_oe && column_strobe_n && nc == 0) npre++;
      done = (nsu + ns + nt > 0) && !sel && row_strobe_n;
    end
    if (!done) begin
      errors++;
      end_of_test();
    end
    @(posedge pclk);
    stall <= 8'h00;
    prev_bw = (t.burst && wr) ? int'(a) : -2;
    if (t.burst) begin
      check(nc, 2);
      check(wr ? nw : nro, wr ? 2 : 3);
      if (wr) check(npre >= 2, first);
    end else begin
      check(nsu, at_least1(wr ? t.ws : t.rs));
      check(nt, tail(wr, wr ? t.wh : t.rh));
      check(bad, 0);
      if (st == 8'h00) check(ns, at_least1(wr ? t.write_strobe_cycles : t.rst));
      else check(nr >= 3 && nr <= 4 && ns > st, 1'b1);
    end
    q = 32'h1;
    for (int i = 0; i < 40 && q[0] !== 1'b0; i++) begin
      apb(1'b0, 8'h20, 32'h0, q, e);
    end
    check(q[0], 1'b0);
    if (wr) begin
      shadow[a[3:0]] = d;
    end else begin
      apb(1'b0, 8'h1c, 32'h0, q, e);
      check(q, shadow[a[3:0]]);
    end
  endtask : run
  // Main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall = 8'h00;
    foreach (shadow[i]) shadow[i] = 32'h0;
    void'($urandom(23251));
    repeat (3) @(posedge pclk);
    check({chip_space_select_n, async_read_strobe_n, async_write_strobe_n,
           half_rate_clock_out}, 7'h7e);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      @(negedge pclk);
      hc_prev = half_rate_clock_out;
      @(negedge pclk);
      check(half_rate_clock_out, !hc_prev);
    end
    @(posedge pclk);
    $display("Test reset and half rate clock done");
    apb(1'b1, 8'h04, 32'hffffffff, q, e);
    apb(1'b0, 8'h04, 32'h0, q, e);
    check(q, 32'h9fff1fff);
    apb(1'b0, 8'h24, 32'h0, q, e);
    check(e, 1'b1);
    $display("Test registers done");
    tm = '0;
    run(2'd0, 1'b0, tm, 20'h1, 8'h00);
    run(2'd1, 1'b1, tm, 20'h2, 8'h00);
    for (int i = 0; i < 10; i++) begin
      tm = '0;
      {tm.rs, tm.ws} = {4'($urandom % 5), 4'($urandom % 5)};
      {tm.rst, tm.write_strobe_cycles} = {6'($urandom % 9), 6'($urandom % 9)};
      {tm.rh, tm.wh} = 6'($urandom);
      run(2'($urandom % 3), 1'($urandom), tm, 20'($urandom % 4), 8'h00);
    end
    $display("Test plain accesses done");
    tm = '0;
    {tm.rs, tm.rst, tm.ws, tm.write_strobe_cycles} = {4'd3, 6'd4, 4'd3, 6'd4};
    run(2'd2, 1'b1, tm, 20'h3, 8'd8);
    run(2'd2, 1'b0, tm, 20'h3, 8'd8);
    $display("Test ready stretch done");
    tm = '0;
    tm.burst = 1'b1;
    run(2'd3, 1'b1, tm, 20'h5, 8'h00);
    run(2'd3, 1'b1, tm, 20'h6, 8'h00);
    run(2'd3, 1'b0, tm, 20'h5, 8'h00);
    $display("Test burst done");
    end_of_test();
  end
endmodule : testbench
